//--- verilog/pwmt_defs.vh
// pwmt_defs.vh: register offsets, field positions and reset values
// assumes a plain address/strobe register port with 8-bit data
`ifndef PWMT_DEFS_VH
`define PWMT_DEFS_VH

`define PWMT_ADDR_W 4
// control register: bit7 comparator_result(ro), 6:5 stored and read back only, 4 wave_output_enable,
// 3 count_enable, 2:0 prescale select
`define PWMT_CTRL_ADDR 4'hB
`define PWMT_STAT_ADDR 4'hF
`define PWMT_HIGH_ADDR 4'h7
`define PWMT_CNT_LO_ADDR 4'h8
`define PWMT_PRD_LO_ADDR 4'h9
`define PWMT_DUTY_LO_ADDR 4'hA
`define PWMT_MASK_ADDR 4'h1
`define PWMT_CTRL_RESET 8'h00
`define PWMT_CTRL_WOE_BIT 4
`define PWMT_CTRL_CEN_BIT 3
`define PWMT_STAT_PMF_BIT 4
`define PWMT_MASK_PMF_BIT 4
`define PWMT_VECTOR 12'h00F
`define PWMT_PRIORITY 3'h5

`endif

//--- verilog/pwmt_timer.v
// pwmt_timer.v: 10-bit waveform counter, prescaler, period/duty compare and register port
// assumes a synchronous register master on sys_clk; sleep_req comes from the core clock domain
//
// Behaviour
// - 10-bit up-counter behind programmable prescaler
// - counter readable only, writes ignored
// - count_enable bit three stops or runs counter
// - period match: clear, output high, latch duty
// - zero duty keeps output low at restart
// - period match sets period_match_flag
// - period is (period+1) times prescale ticks
// - duty latch equal counter drives output low
// - duty write any time, latched at restart
// - period register write sets match value
// - three-bit prescale select, eight ratios
// - prescaler cleared by every reset
// - counter halts during sleep
// - match resets counter, sets flag same cycle
// - interrupt vector 00FH, priority five
// - flag set regardless of mask; request is AND
`timescale 1ns/10ps
`include "pwmt_defs.vh"

module pwmt_timer (
	// clock and reset
	input wire sys_clk,
	input wire arst_n,
	// register port
	input wire [`PWMT_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// power state and comparator status from the core
	input wire sleep_req,
	input wire comparator_result,
	// waveform pin and interrupt request
	output reg wave_output_pin,
	output reg irq_req,
	output reg [11:0] irq_vector,
	output reg [2:0] irq_priority
);

	// control and datapath registers
	reg [7:0] ctrl_r;
	reg [9:0] wave_counter_r;
	reg [9:0] period_value_r;
	reg [9:0] pending_duty_r;
	reg [9:0] duty_compare_latch_r;
	reg [7:0] presc_r;
	reg period_match_flag_r;
	reg irq_mask_r;

	// synchroniser stages
	reg sleep_s1_r;
	reg sleep_s2_r;
	reg cmp_s1_r;
	reg cmp_s2_r;

	// combinational decode
	reg tick;
	reg [7:0] rd_mux;
	wire count_enable;
	wire wave_output_enable;
	wire period_hit;
	wire counting;
	wire count_step;
	wire period_restart;
	wire [9:0] counter_next;
	wire duty_reached;
	wire flag_clear;

	assign count_enable = ctrl_r[`PWMT_CTRL_CEN_BIT];
	assign wave_output_enable = ctrl_r[`PWMT_CTRL_WOE_BIT];
	// sleep halts counting; synchronised since it may come from a gated core clock
	assign counting = count_enable & ~sleep_s2_r;
	assign period_hit = (wave_counter_r == period_value_r);

	assign count_step = counting & tick;
	// the match and the flag share one strobe so they land on the same edge
	assign period_restart = count_step & period_hit;
	assign counter_next = wave_counter_r + 10'h001;
	assign duty_reached = (counter_next == duty_compare_latch_r);
	assign flag_clear = reg_wr && (reg_addr == `PWMT_STAT_ADDR) &&
		!reg_wdata[`PWMT_STAT_PMF_BIT];

	// two-flop synchronisers; only the second stage is read
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sleep_s1_r <= 1'b0;
			sleep_s2_r <= 1'b0;
		end else begin
			sleep_s1_r <= sleep_req;
			sleep_s2_r <= sleep_s1_r;
		end
	end

	// comparator level is only read back, never acted upon here
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cmp_s1_r <= 1'b0;
			cmp_s2_r <= 1'b0;
		end else begin
			cmp_s1_r <= comparator_result;
			cmp_s2_r <= cmp_s1_r;
		end
	end

	// prescale tick: ratios 1,2,4,8,16,64,128,256 for codes 0..7
	// the prescaler is not cleared on a select change, so the first tick
	// after a change may come early; the period after it is exact
	always @* begin
		tick = 1'b0;
		case (ctrl_r[2:0])
			3'h0: begin
				tick = 1'b1;
			end
			3'h1: begin
				tick = (presc_r[0:0] == 1'h1);
			end
			3'h2: begin
				tick = (presc_r[1:0] == 2'h3);
			end
			3'h3: begin
				tick = (presc_r[2:0] == 3'h7);
			end
			3'h4: begin
				tick = (presc_r[3:0] == 4'hF);
			end
			3'h5: begin
				tick = (presc_r[5:0] == 6'h3F);
			end
			3'h6: begin
				tick = (presc_r[6:0] == 7'h7F);
			end
			default: begin
				tick = (presc_r == 8'hFF);
			end
		endcase
	end

	// prescaler cleared by reset; frozen, not cleared, while stopped
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			presc_r <= 8'h00;
		end else if (counting) begin
			presc_r <= presc_r + 8'h01;
		end
	end

	// counter steps once per prescaler tick and clears on the tick that sees a period match
	// a period below the current count lets it run through 1023 and wrap first
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wave_counter_r <= 10'h000;
		end else if (period_restart) begin
			wave_counter_r <= 10'h000;
		end else if (count_step) begin
			wave_counter_r <= counter_next;
		end
	end

	// duty latch loads only at restart, so a mid-period write cannot cut a pulse
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			duty_compare_latch_r <= 10'h000;
		end else if (period_restart) begin
			duty_compare_latch_r <= pending_duty_r;
		end
	end

	// waveform pin; held low whenever the output enable is clear
	// a duty above the period keeps the pin high for the whole period
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wave_output_pin <= 1'b0;
		end else if (!wave_output_enable) begin
			wave_output_pin <= 1'b0;
		end else if (period_restart) begin
			// zero duty never raises the pin
			wave_output_pin <= (pending_duty_r != 10'h000);
		end else if (count_step && duty_reached) begin
			wave_output_pin <= 1'b0;
		end
	end

	// registers; counter low byte and high bits accept no writes
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r <= `PWMT_CTRL_RESET;
			period_value_r <= 10'h000;
			pending_duty_r <= 10'h000;
			irq_mask_r <= 1'b0;
		end else if (reg_wr) begin
			case (reg_addr)
				`PWMT_CTRL_ADDR: begin
					// read-only comparator bit is never stored
					ctrl_r <= {1'b0, reg_wdata[6:0]};
				end
				`PWMT_PRD_LO_ADDR: begin
					period_value_r[7:0] <= reg_wdata;
				end
				`PWMT_DUTY_LO_ADDR: begin
					pending_duty_r[7:0] <= reg_wdata;
				end
				`PWMT_HIGH_ADDR: begin
					period_value_r[9:8] <= reg_wdata[3:2];
					pending_duty_r[9:8] <= reg_wdata[1:0];
				end
				`PWMT_MASK_ADDR: begin
					irq_mask_r <= reg_wdata[`PWMT_MASK_PMF_BIT];
				end
				default: begin
					// counter address and unmapped writes are dropped
				end
			endcase
		end
	end

	// software clears by writing zero; a match in the same cycle wins
	// setting has priority so that no match is ever lost
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			period_match_flag_r <= 1'b0;
		end else if (period_restart) begin
			period_match_flag_r <= 1'b1;
		end else if (flag_clear) begin
			period_match_flag_r <= 1'b0;
		end
	end

	// read mux; unmapped addresses read as zero
	always @* begin
		rd_mux = 8'h00;
		case (reg_addr)
			`PWMT_CTRL_ADDR: begin
				rd_mux = {cmp_s2_r, ctrl_r[6:0]};
			end
			`PWMT_HIGH_ADDR: begin
				rd_mux = {2'h0, wave_counter_r[9:8], period_value_r[9:8],
					pending_duty_r[9:8]};
			end
			`PWMT_CNT_LO_ADDR: begin
				rd_mux = wave_counter_r[7:0];
			end
			`PWMT_PRD_LO_ADDR: begin
				rd_mux = period_value_r[7:0];
			end
			`PWMT_DUTY_LO_ADDR: begin
				rd_mux = pending_duty_r[7:0];
			end
			`PWMT_STAT_ADDR: begin
				rd_mux = {3'h0, period_match_flag_r, 4'h0};
			end
			`PWMT_MASK_ADDR: begin
				rd_mux = {3'h0, irq_mask_r, 4'h0};
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
	end

	// data stand one cycle after the strobe and are zero otherwise
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// request is flag AND mask, registered so the core sees a clean level
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_req <= 1'b0;
		end else begin
			irq_req <= period_match_flag_r & irq_mask_r;
		end
	end

	// vector and priority are fixed for this source; zero in reset and until the first clock after it
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_vector <= 12'h000;
			irq_priority <= 3'h0;
		end else begin
			irq_vector <= `PWMT_VECTOR;
			irq_priority <= `PWMT_PRIORITY;
		end
	end

endmodule // pwmt_timer

//--- verification/pwmt_timer_asserts.sv
// port checker for pwmt_timer
// assumes bind into pwmt_timer, one clock
`timescale 1ns/10ps
module pwmt_chk (
	// clock, reset, register port
	input wire sys_clk,
	input wire arst_n,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	// core side
	input wire sleep_req,
	input wire wave_output_pin,
	input wire irq_req,
	input wire [11:0] irq_vector,
	input wire [2:0] irq_priority
);
	reg [6:0] ctl_r;
	reg msk_r;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_r <= 7'h00;
			msk_r <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr == 4'hB)
				ctl_r <= reg_wdata[6:0];
			if (reg_addr == 4'h1)
				msk_r <= reg_wdata[4];
		end
	end
	chk_vec_fixed: assert property ($past(arst_n) |-> irq_vector == 12'h00F)
		else $error("vector");
	chk_prio_fixed: assert property ($past(arst_n) |-> irq_priority == 3'h5)
		else $error("priority");
	chk_ctl_read: assert property (reg_rd && reg_addr == 4'hB |=> reg_rdata[6:0] == ctl_r)
		else $error("control");
	chk_pin_off: assert property (wave_output_pin |-> $past(ctl_r[4]))
		else $error("pin");
	chk_irq_mask: assert property (irq_req |-> $past(msk_r))
		else $error("irq");
	// counts from the third synchronised edge, so pin must freeze by the fifth
	chk_sleep_hold: assert property ((sleep_req && !reg_wr)[*5] |-> $stable(wave_output_pin))
		else $error("sleep");
	chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("idle");
	chk_rd_unmap: assert property (reg_rd && reg_addr < 4'h7 && reg_addr != 4'h1 |=> !reg_rdata)
		else $error("unmapped");
endmodule // pwmt_chk
bind pwmt_timer pwmt_chk u_pwmt_chk (.*);

//--- verification/pwmt_timer_tb_top.sv
// bench for pwmt_timer over its register port
// assumes 250 MHz sys_clk
`timescale 1ns/10ps
module pwmt_timer_tb_top;
	reg sys_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	reg sleep_req = 1'b0, comparator_result = 1'b0;
	reg [3:0] reg_addr = 4'h0;
	reg [7:0] reg_wdata = 8'h00, d;
	reg [15:0] a, b, r;
	wire [7:0] reg_rdata;
	wire wave_output_pin, irq_req;
	wire [11:0] irq_vector;
	wire [2:0] irq_priority;
	integer num_errors = 0, check_count = 0, i;
	initial forever #2 sys_clk = ~sys_clk;
	pwmt_timer u_pwmt_timer (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.sleep_req(sleep_req),
		.comparator_result(comparator_result),
		.wave_output_pin(wave_output_pin),
		.irq_req(irq_req),
		.irq_vector(irq_vector),
		.irq_priority(irq_priority)
	);
	task io(input w, input [3:0] ad, input [7:0] v);
		begin
			@(posedge sys_clk);
			reg_addr <= ad;
			reg_wdata <= v;
			reg_wr <= w;
			reg_rd <= !w;
			@(posedge sys_clk);
			reg_wr <= 1'b0;
			reg_rd <= 1'b0;
			#1 d = reg_rdata;
		end
	endtask
	task chk(input [15:0] g, input [15:0] x);
		begin
			check_count = check_count + 1;
			if (g !== x) begin
				num_errors = num_errors + 1;
				$display("ERROR %0t mismatch %h %h", $time, g, x);
			end
		end
	endtask
	task report_and_stop;
		begin
			$display("checks %0d errors %0d", check_count, num_errors);
			if (num_errors == 0 && check_count > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	task wt(input v, output [15:0] c);
		begin
			c = 16'h0000;
			while (wave_output_pin !== v) begin
				@(negedge sys_clk);
				c = c + 16'h0001;
				if (c > 16'h0C00) begin
					num_errors = num_errors + 1;
					report_and_stop;
				end
			end
		end
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		arst_n <= 1'b1;
		io(1'b1, 4'h8, 8'h55);
		io(1'b0, 4'h8, 8'h00);
		chk(d, 8'h00);
		io(1'b0, 4'h2, 8'h00);
		chk(d, 8'h00);
		io(1'b1, 4'h9, 8'h04);
		io(1'b1, 4'hA, 8'h02);
		for (i = 0; i < 8; i = i + 1) begin
			io(1'b1, 4'hB, {5'h03, i[2:0]});
			wt(1'b0, a);
			wt(1'b1, a);
			wt(1'b0, a);
			wt(1'b1, b);
			r = 16'h0001 << ((i < 5) ? i : i + 1);
			chk(a, r << 1);
			chk(a + b, 16'h0005 * r);
		end
		// zero duty is latched at the next restart, after which the pin stays low
		io(1'b1, 4'hA, 8'h00);
		io(1'b1, 4'hB, 8'h18);
		io(1'b0, 4'hB, 8'h00);
		chk(d, 16'h0018);
		repeat (12) @(posedge sys_clk);
		a = 16'h0000;
		repeat (20) begin
			@(negedge sys_clk);
			if (wave_output_pin !== 1'b0)
				a = a + 16'h0001;
		end
		chk(a, 16'h0000);
		$display("waveform done");
		io(1'b0, 4'hF, 8'h00);
		chk(d[4], 1'b1);
		chk(irq_vector, 16'h000F);
		chk(irq_priority, 16'h0005);
		io(1'b1, 4'h1, 8'h10);
		@(posedge sys_clk);
		#1;
		chk(irq_req, 1'b1);
		io(1'b1, 4'h9, 8'hFF);
		io(1'b1, 4'hB, 8'h08);
		io(1'b0, 4'h8, 8'h00);
		a[7:0] = d;
		io(1'b0, 4'h8, 8'h00);
		b[7:0] = d - a[7:0];
		chk(b[7:0], 8'h02);
		@(posedge sys_clk);
		sleep_req <= 1'b1;
		comparator_result <= 1'b1;
		repeat (4) @(posedge sys_clk);
		io(1'b0, 4'h8, 8'h00);
		a[7:0] = d;
		io(1'b0, 4'h8, 8'h00);
		chk(d, a[7:0]);
		io(1'b0, 4'hB, 8'h00);
		chk(d, 16'h0088);
		io(1'b1, 4'hF, 8'h00);
		io(1'b0, 4'hF, 8'h00);
		chk(d[4], 1'b0);
		chk(irq_req, 1'b0);
		$display("timer done");
		report_and_stop;
	end
endmodule // pwmt_timer_tb_top
